// ---- dv/csrv_top_bench.sv ----
// self-checking bench for the core status reset-value block
`timescale 1ns/1ns
`include "csrv_params.svh"
module csrv_top_bench;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic pready, pslverr, er, m, host_irq_level, clock_output_enable, reset_isr_req, irq;
  logic sw_reset_pulse = 0, bus_error_event = 0, boot_mode_pin = 1;
  int bad_count = 0, compares = 0;
  always #4 pclk = ~pclk;
  csrv_top u_csrv_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sw_reset_pulse(sw_reset_pulse), .bus_error_event(bus_error_event),
    .boot_mode_pin(boot_mode_pin), .host_irq_level(host_irq_level),
    .clock_output_enable(clock_output_enable), .reset_isr_req(reset_isr_req), .irq(irq));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check_val(input logic [31:0] got, input logic [31:0] exp, input string s);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: %s got %h want %h", $time, s, got, exp);
    end
  endtask : check_val
  task automatic check_pin(input logic got, input logic exp, input string s);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: pin %s got %b", $time, s, got);
    end
  endtask : check_pin
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) check_pin(1'b0, 1'b1, "pready");
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
  endtask : apb
  task automatic rd_exp(input logic [11:0] a, input logic [31:0] e, input string s);
    apb(1'b0, a, 32'h0);
    check_val(rd, e, s);
  endtask : rd_exp
  task automatic pulse(input logic sw);
    @(posedge pclk);
    if (sw) sw_reset_pulse <= 1;
    else bus_error_event <= 1;
    @(posedge pclk);
    sw_reset_pulse <= 0;
    bus_error_event <= 0;
    repeat (2) @(posedge pclk);
  endtask : pulse
  task automatic hw_reset(input logic pin);
    logic seen;
    seen = 0;
    @(posedge pclk);
    presetn <= 0;
    boot_mode_pin <= pin;
    m = pin;
    repeat (10) @(posedge pclk);
    check_pin(host_irq_level, 1'b1, "host");
    check_pin(clock_output_enable, 1'b1, "clkoe");
    presetn <= 1;
    repeat (6) begin
      @(posedge pclk);
      if (reset_isr_req === 1'b1) seen = 1;
    end
    check_pin(seen, 1'b1, "isr");
  endtask : hw_reset
  ////////////////////////////////////////////////////////////////////////////////
  task automatic test_hw;
    rd_exp(`CSRV_OFF_ST3, 32'h1000, "st3");
    rd_exp(`CSRV_OFF_ST4, 32'h1000 | 32'(m) << 6, "st4");
    rd_exp(`CSRV_OFF_TMP2, 32'h0, "tmp2");
    apb(1'b0, `CSRV_OFF_XDP, 32'h0);
    check_val(rd & 32'h007F0000, 32'h0, "xdp");
    rd_exp(`CSRV_OFF_CTRL, 32'h0, "ctrl");
    rd_exp(`CSRV_OFF_IRQ_STAT, 32'h4, "stat");
    $display("test hw values done");
  endtask : test_hw
  task automatic test_irq;
    apb(1'b1, `CSRV_OFF_IRQ_MASK, 32'h7);
    pulse(1'b0);
    check_pin(irq, 1'b1, "irq");
    rd_exp(`CSRV_OFF_ST4, 32'h1080 | 32'(m) << 6, "berr");
    rd_exp(`CSRV_OFF_IRQ_STAT, 32'h1, "stat");
    repeat (2) @(posedge pclk);
    check_pin(irq, 1'b0, "irq clr");
    apb(1'b1, `CSRV_OFF_ST4, 32'h1080);
    rd_exp(`CSRV_OFF_ST4, 32'h1000 | 32'(m) << 6, "berr clr");
    apb(1'b0, 12'h0FC, 32'h0);
    check_pin(er, 1'b1, "slverr");
    check_val(rd, 32'h0, "unmapped");
    $display("test irq done");
  endtask : test_irq
  task automatic test_sw;
    apb(1'b1, `CSRV_OFF_ST3, 32'hFFFF);
    apb(1'b1, `CSRV_OFF_ST4, 32'hE027);
    apb(1'b1, `CSRV_OFF_TMP2, 32'hFFFF);
    apb(1'b1, `CSRV_OFF_XDP, 32'h7FFFFF);
    apb(1'b1, `CSRV_OFF_EXT_AUX_POINTER_0, 32'h7FFFFF);
    apb(1'b1, `CSRV_OFF_XSP, 32'h7FFFFF);
    rd_exp(`CSRV_OFF_ST3, 32'h9DFF, "st3 wr");
    rd_exp(`CSRV_OFF_ST4, 32'hE027 | 32'(m) << 6, "st4 wr");
    rd_exp(`CSRV_OFF_CTRL, 32'h1, "ctrl wr");
    pulse(1'b1);
    check_pin(irq, 1'b1, "irq sw");
    rd_exp(`CSRV_OFF_ST3, 32'h107F, "st3 sw");
    rd_exp(`CSRV_OFF_ST4, 32'hE007 | 32'(m) << 6, "st4 sw");
    rd_exp(`CSRV_OFF_TMP2, 32'h0, "tmp2 sw");
    rd_exp(`CSRV_OFF_XDP, 32'h7F007F, "xdp sw");
    rd_exp(`CSRV_OFF_EXT_AUX_POINTER_0, 32'h7FFFFF, "ext_aux_pointer_0 sw");
    rd_exp(`CSRV_OFF_XSP, 32'h7FFFFF, "xsp sw");
    rd_exp(`CSRV_OFF_CTRL, 32'h1, "ctrl sw");
    rd_exp(`CSRV_OFF_IRQ_STAT, 32'h2, "stat sw");
    check_pin(host_irq_level, 1'b0, "host sw");
    check_pin(clock_output_enable, 1'b0, "clkoe sw");
    hw_reset(1'b0);
    rd_exp(`CSRV_OFF_ST4, 32'h1000, "st4 hw");
    apb(1'b0, `CSRV_OFF_XDP, 32'h0);
    check_val(rd & 32'h007F0000, 32'h0, "xdp hw");
    rd_exp(`CSRV_OFF_TMP2, 32'h0, "tmp2 hw");
    $display("test sw reset done");
  endtask : test_sw
  ////////////////////////////////////////////////////////////////////////////////
  task automatic complete_run;
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : complete_run
  initial begin
    hw_reset(1'b1);
    test_hw();
    test_irq();
    test_sw();
    complete_run();
  end
  initial begin
    repeat (5000) @(posedge pclk);
    bad_count++;
    complete_run();
  end
endmodule : csrv_top_bench

// ---- rtl/csrv_params.svh ----
// constants for the core status reset-value block
// Functional notes
// R1 - both resets clear circular select bits 7 and 8 of status three
// R2 - both resets clear round select bit 10
// R3 - both resets clear emulation write permit bit 11
// R4 - both resets set debug mask bit 12
// R5 - both resets clear pointer operand mode bit 15
// R6 - hardware reset clears store saturate bit 0; software reset keeps it
// R7 - hardware reset clears multiply saturate bit 1; software reset keeps it
// R8 - hardware reset clears clock output disable bit 2; software reset keeps it
// R9 - both resets clear address unit saturate bit 5
// R10 - hardware reset loads boot memory mode bit 6 from pins; software keeps
// R11 - hardware reset clears bus error flag bit 7; hardware event sets it
// R12 - hardware reset sets host interrupt bit 12; software reset keeps it
// R13 - hardware reset clears cache flush bit 13; software reset keeps it
// R14 - hardware reset clears cache enable 14 and freeze 15; software keeps
// R15 - both resets clear all bits of temporary two
// R16 - hardware clears data page bits 22:16; software clears only 15:7
// R17 - software reset touches only listed fields; others keep values
// R18 - hardware reset aborts work, then requests reset service routine
// R19 - reserved status bits read back as zero
`ifndef CSRV_PARAMS_SVH
`define CSRV_PARAMS_SVH
`define CSRV_OFF_ST3 12'h000
`define CSRV_OFF_ST4 12'h004
`define CSRV_OFF_TMP2 12'h008
`define CSRV_OFF_XDP 12'h00C
`define CSRV_OFF_EXT_AUX_POINTER_0 12'h010
`define CSRV_OFF_XSP 12'h014
`define CSRV_OFF_IRQ_STAT 12'h018
`define CSRV_OFF_IRQ_MASK 12'h01C
`define CSRV_OFF_CTRL 12'h020
`define CSRV_ST3_WMASK 16'h9DFF
`define CSRV_ST3_SWCLR 16'h8D80
`define CSRV_ST3_SWSET 16'h1000
`define CSRV_ST3_HWRST 16'h1000
`define CSRV_ST4_WMASK 16'hF027
`define CSRV_ST4_HWRST 16'h1000
`define CSRV_ST4_ADDRESS_UNIT_SATURATE 5
`define CSRV_ST4_MODE 6
`define CSRV_ST4_BERR 7
`define CSRV_XDP_SWMASK 23'h00FF80
`define CSRV_IRQ_BERR 0
`define CSRV_IRQ_SWRST 1
`define CSRV_IRQ_HWDONE 2
`endif

// ---- rtl/csrv_pkg.sv ----
// types for the core status reset-value block
package csrv_pkg;
  typedef logic [15:0] csrv_word_t;
  typedef logic [22:0] csrv_xptr_t;
endpackage : csrv_pkg

// ---- rtl/csrv_top.sv ----
// status and pointer registers with hardware and software reset values
`timescale 1ns/1ns
`include "csrv_params.svh"
module csrv_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sw_reset_pulse,
  input wire logic bus_error_event,
  input wire logic boot_mode_pin,
  output logic host_irq_level,
  output logic clock_output_enable,
  output logic reset_isr_req,
  output logic irq
);
  import csrv_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchroniser
  logic boot_s1_reg;
  logic boot_s2_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      boot_s1_reg <= 1'b0;
      boot_s2_reg <= 1'b0;
    end else begin
      boot_s1_reg <= boot_mode_pin;
      boot_s2_reg <= boot_s1_reg;
    end
  end

  // second clock after release: synchroniser now holds the strap, capture it once
  logic hw_first_reg;
  logic hw_first_done_reg;
  logic hw_wait_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hw_wait_reg <= 1'b0;
      hw_first_reg <= 1'b0;
      hw_first_done_reg <= 1'b0;
    end else begin
      hw_wait_reg <= 1'b1;
      hw_first_done_reg <= hw_wait_reg;
      hw_first_reg <= hw_wait_reg && !hw_first_done_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb decode
  logic wr_en;
  logic rd_en;
  logic addr_ok;
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && penable && !pwrite;
  assign addr_ok = (paddr == `CSRV_OFF_ST3) || (paddr == `CSRV_OFF_ST4) ||
                   (paddr == `CSRV_OFF_TMP2) || (paddr == `CSRV_OFF_XDP) ||
                   (paddr == `CSRV_OFF_EXT_AUX_POINTER_0) || (paddr == `CSRV_OFF_XSP) ||
                   (paddr == `CSRV_OFF_IRQ_STAT) || (paddr == `CSRV_OFF_IRQ_MASK) ||
                   (paddr == `CSRV_OFF_CTRL);

  ////////////////////////////////////////////////////////////////////////////
  // status three
  csrv_word_t st3_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st3_reg <= `CSRV_ST3_HWRST; // R1 R2 R3 R4 R5 R18
    end else if (sw_reset_pulse) begin
      st3_reg <= (st3_reg & ~`CSRV_ST3_SWCLR) | `CSRV_ST3_SWSET; // R1 R2 R3 R4 R5 R17
    end else if (wr_en && paddr == `CSRV_OFF_ST3) begin
      st3_reg <= pwdata[15:0] & `CSRV_ST3_WMASK; // R19
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // status four
  csrv_word_t st4_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st4_reg <= `CSRV_ST4_HWRST; // R6 R7 R8 R9 R11 R12 R13 R14
    end else begin
      if (hw_first_reg) begin
        st4_reg[`CSRV_ST4_MODE] <= boot_s2_reg; // R10
      end else if (sw_reset_pulse) begin
        st4_reg[`CSRV_ST4_ADDRESS_UNIT_SATURATE] <= 1'b0; // R9 R17
      end else if (wr_en && paddr == `CSRV_OFF_ST4) begin
        st4_reg <= (pwdata[15:0] & `CSRV_ST4_WMASK) |
                   (st4_reg & 16'h00C0); // R10 R19
        if (pwdata[`CSRV_ST4_BERR]) begin
          st4_reg[`CSRV_ST4_BERR] <= 1'b0;
        end
      end
      if (bus_error_event) begin
        st4_reg[`CSRV_ST4_BERR] <= 1'b1; // R11
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // temporary two and extended pointers
  csrv_word_t tmp2_reg;
  csrv_xptr_t xdp_reg;
  csrv_xptr_t ext_aux_pointer_0_reg;
  csrv_xptr_t xsp_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tmp2_reg <= 16'h0000; // R15
    end else if (sw_reset_pulse) begin
      tmp2_reg <= 16'h0000; // R15
    end else if (wr_en && paddr == `CSRV_OFF_TMP2) begin
      tmp2_reg <= pwdata[15:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      xdp_reg <= 23'h000000; // R16
    end else if (sw_reset_pulse) begin
      xdp_reg <= xdp_reg & ~`CSRV_XDP_SWMASK; // R16
    end else if (wr_en && paddr == `CSRV_OFF_XDP) begin
      xdp_reg <= pwdata[22:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_aux_pointer_0_reg <= 23'h000000;
      xsp_reg <= 23'h000000;
    end else if (!sw_reset_pulse && wr_en) begin // R17
      if (paddr == `CSRV_OFF_EXT_AUX_POINTER_0) begin
        ext_aux_pointer_0_reg <= pwdata[22:0];
      end
      if (paddr == `CSRV_OFF_XSP) begin
        xsp_reg <= pwdata[22:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupts
  logic [2:0] irq_stat_reg;
  logic [2:0] irq_mask_reg;
  logic [2:0] irq_ev;
  assign irq_ev = {hw_first_reg, sw_reset_pulse, bus_error_event};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_reg <= 3'h0;
    end else if (rd_en && paddr == `CSRV_OFF_IRQ_STAT) begin
      irq_stat_reg <= irq_ev;
    end else begin
      irq_stat_reg <= irq_stat_reg | irq_ev;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_mask_reg <= 3'h0;
    end else if (wr_en && paddr == `CSRV_OFF_IRQ_MASK) begin
      irq_mask_reg <= pwdata[2:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      host_irq_level <= 1'b1; // R12
      clock_output_enable <= 1'b1; // R8
      reset_isr_req <= 1'b0;
      irq <= 1'b0;
    end else begin
      host_irq_level <= st4_reg[12];
      clock_output_enable <= !st4_reg[2];
      reset_isr_req <= hw_first_reg; // R18
      irq <= |(irq_stat_reg & irq_mask_reg);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !addr_ok;
      prdata <= 32'h00000000;
      if (psel && !penable && !pwrite) begin
        unique case (paddr)
          `CSRV_OFF_ST3: prdata <= {16'h0000, st3_reg};
          `CSRV_OFF_ST4: prdata <= {16'h0000, st4_reg};
          `CSRV_OFF_TMP2: prdata <= {16'h0000, tmp2_reg};
          `CSRV_OFF_XDP: prdata <= {9'h000, xdp_reg};
          `CSRV_OFF_EXT_AUX_POINTER_0: prdata <= {9'h000, ext_aux_pointer_0_reg};
          `CSRV_OFF_XSP: prdata <= {9'h000, xsp_reg};
          `CSRV_OFF_IRQ_STAT: prdata <= {29'h00000000, irq_stat_reg};
          `CSRV_OFF_IRQ_MASK: prdata <= {29'h00000000, irq_mask_reg};
          `CSRV_OFF_CTRL: prdata <= {31'h00000000, st4_reg[13]};
          default: prdata <= 32'h00000000;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  a_sw_clears_st3: assert property (@(posedge pclk) disable iff (!presetn)
    sw_reset_pulse |=> (st3_reg[8:7] == 2'b00) && !st3_reg[10] && !st3_reg[11]
      && st3_reg[12] && !st3_reg[15]) // R1
    else $error("status three not reset by software reset");
  a_sw_round_clear: assert property (@(posedge pclk) disable iff (!presetn)
    sw_reset_pulse |=> !st3_reg[10]) // R2
    else $error("round select not cleared");
  a_sw_emu_clear: assert property (@(posedge pclk) disable iff (!presetn)
    sw_reset_pulse |=> !st3_reg[11]) // R3
    else $error("emulation permit not cleared");
  a_sw_debug_set: assert property (@(posedge pclk) disable iff (!presetn)
    sw_reset_pulse |=> st3_reg[12]) // R4
    else $error("debug mask not set");
  a_sw_keep_sat: assert property (@(posedge pclk) disable iff (!presetn)
    sw_reset_pulse && !hw_first_reg |=> st4_reg[2:0] == $past(st4_reg[2:0])) // R6
    else $error("software reset changed kept bits");
  a_sw_address_unit_saturate_clear: assert property (@(posedge pclk) disable iff (!presetn)
    sw_reset_pulse && !hw_first_reg |=> !st4_reg[5]) // R9
    else $error("address saturate not cleared");
  a_berr_sticky: assert property (@(posedge pclk) disable iff (!presetn)
    bus_error_event |=> st4_reg[7]) // R11
    else $error("bus error flag not set");
  a_tmp2_clear: assert property (@(posedge pclk) disable iff (!presetn)
    sw_reset_pulse |=> tmp2_reg == 16'h0000) // R15
    else $error("temporary two not cleared");
  a_xdp_partial: assert property (@(posedge pclk) disable iff (!presetn)
    sw_reset_pulse |=> xdp_reg[15:7] == 9'h000 && xdp_reg[22:16] == $past(xdp_reg[22:16])
      && xdp_reg[6:0] == $past(xdp_reg[6:0])) // R16
    else $error("data page software reset wrong");
  a_reserved_zero: assert property (@(posedge pclk) disable iff (!presetn)
    st3_reg[9] == 1'b0 && st3_reg[14:13] == 2'b00 && st4_reg[4:3] == 2'b00
      && st4_reg[11:8] == 4'h0) // R19
    else $error("reserved status bit set");
  a_isr_request: assert property (@(posedge pclk) disable iff (!presetn)
    hw_first_reg |=> reset_isr_req ##1 !reset_isr_req) // R18
    else $error("reset service request wrong");

  ////////////////////////////////////////////////////////////////////////////
  // software reset field checks and boot mode strap capture check
  a_ptr7_linear_sw: assert property (@(posedge pclk) disable iff (!presetn) // R1
    sw_reset_pulse |=> !st3_reg[7])
    else $error("pointer 7 circular select not cleared");

  a_coef_linear_sw: assert property (@(posedge pclk) disable iff (!presetn) // R1
    sw_reset_pulse |=> !st3_reg[8])
    else $error("coefficient circular select not cleared");

  a_pointer_operand_mode_clear_sw: assert property (@(posedge pclk) disable iff (!presetn) // R5
    sw_reset_pulse |=> !st3_reg[15])
    else $error("pointer operand mode not cleared");

  a_sst_keep_sw: assert property (@(posedge pclk) disable iff (!presetn) // R6
    sw_reset_pulse && !hw_first_reg |=> st4_reg[0] == $past(st4_reg[0]))
    else $error("store saturate changed by software reset");

  a_multiply_saturate_keep_sw: assert property (@(posedge pclk) disable iff (!presetn) // R7
    sw_reset_pulse && !hw_first_reg |=> st4_reg[1] == $past(st4_reg[1]))
    else $error("multiply saturate changed by software reset");

  a_clock_output_disable_keep_sw: assert property (@(posedge pclk) disable iff (!presetn) // R8
    sw_reset_pulse && !hw_first_reg |=> st4_reg[2] == $past(st4_reg[2]))
    else $error("clock output disable changed by software reset");

  a_mode_keep_sw: assert property (@(posedge pclk) disable iff (!presetn) // R10
    sw_reset_pulse && !hw_first_reg |=> st4_reg[6] == $past(st4_reg[6]))
    else $error("boot mode changed by software reset");

  a_mode_capture: assert property (@(posedge pclk) disable iff (!presetn) // R10
    hw_first_reg |=> st4_reg[6] == $past(boot_s2_reg))
    else $error("boot mode strap not captured");

  a_berr_keep_sw: assert property (@(posedge pclk) disable iff (!presetn) // R11
    sw_reset_pulse && !bus_error_event |=> st4_reg[7] == $past(st4_reg[7]))
    else $error("bus error flag changed by software reset");

  a_host_keep_sw: assert property (@(posedge pclk) disable iff (!presetn) // R12
    sw_reset_pulse && !hw_first_reg |=> st4_reg[12] == $past(st4_reg[12]))
    else $error("host interrupt bit changed by software reset");

  a_flush_keep_sw: assert property (@(posedge pclk) disable iff (!presetn) // R13
    sw_reset_pulse && !hw_first_reg |=> st4_reg[13] == $past(st4_reg[13]))
    else $error("cache flush bit changed by software reset");

  a_cache_keep_sw: assert property (@(posedge pclk) disable iff (!presetn) // R14
    sw_reset_pulse && !hw_first_reg |=> st4_reg[15:14] == $past(st4_reg[15:14]))
    else $error("cache enable or freeze changed by software reset");

  a_ext_aux_pointer_0_keep_sw: assert property (@(posedge pclk) disable iff (!presetn) // R17
    sw_reset_pulse |=> ext_aux_pointer_0_reg == $past(ext_aux_pointer_0_reg))
    else $error("aux pointer 0 changed by software reset");

  a_xsp_keep_sw: assert property (@(posedge pclk) disable iff (!presetn) // R17
    sw_reset_pulse |=> xsp_reg == $past(xsp_reg))
    else $error("stack pointer changed by software reset");

  ////////////////////////////////////////////////////////////////////////////
  // pin, flag and bus checks
  a_host_pin_follow: assert property (@(posedge pclk) disable iff (!presetn) // R12
    host_irq_level == $past(st4_reg[12]))
    else $error("host interrupt level does not follow status");

  a_clock_output_pin_follow: assert property (@(posedge pclk) disable iff (!presetn) // R8
    clock_output_enable == !$past(st4_reg[2]))
    else $error("clock output enable does not follow status");

  a_berr_clear_wr: assert property (@(posedge pclk) disable iff (!presetn) // R11
    wr_en && paddr == `CSRV_OFF_ST4 && pwdata[7] && !bus_error_event && !sw_reset_pulse
      && !hw_first_reg |=> !st4_reg[7])
    else $error("bus error flag not cleared by write");

  a_isr_single: assert property (@(posedge pclk) disable iff (!presetn) // R18
    reset_isr_req |=> !reset_isr_req)
    else $error("reset service request too long");

  a_hw_first_once: assert property (@(posedge pclk) disable iff (!presetn) // R18
    hw_first_reg |=> !hw_first_reg)
    else $error("strap capture repeated");

  a_st3_wr_mask: assert property (@(posedge pclk) disable iff (!presetn) // R19
    wr_en && paddr == `CSRV_OFF_ST3 && !sw_reset_pulse
      |=> st3_reg == ($past(pwdata[15:0]) & `CSRV_ST3_WMASK))
    else $error("status three write wrong");

  a_tmp2_write: assert property (@(posedge pclk) disable iff (!presetn)
    wr_en && paddr == `CSRV_OFF_TMP2 && !sw_reset_pulse |=> tmp2_reg == $past(pwdata[15:0]))
    else $error("temporary two write lost");

  a_xdp_write: assert property (@(posedge pclk) disable iff (!presetn)
    wr_en && paddr == `CSRV_OFF_XDP && !sw_reset_pulse |=> xdp_reg == $past(pwdata[22:0]))
    else $error("data page write lost");

  a_ext_aux_pointer_0_write: assert property (@(posedge pclk) disable iff (!presetn) // R17
    wr_en && paddr == `CSRV_OFF_EXT_AUX_POINTER_0 && !sw_reset_pulse |=> ext_aux_pointer_0_reg == $past(pwdata[22:0]))
    else $error("aux pointer 0 write lost");

  a_xsp_write: assert property (@(posedge pclk) disable iff (!presetn) // R17
    wr_en && paddr == `CSRV_OFF_XSP && !sw_reset_pulse |=> xsp_reg == $past(pwdata[22:0]))
    else $error("stack pointer write lost");

  a_mask_write: assert property (@(posedge pclk) disable iff (!presetn)
    wr_en && paddr == `CSRV_OFF_IRQ_MASK |=> irq_mask_reg == $past(pwdata[2:0]))
    else $error("interrupt mask write lost");

  a_berr_event_irq: assert property (@(posedge pclk) disable iff (!presetn)
    bus_error_event |=> irq_stat_reg[0])
    else $error("bus error status not set");

  a_swrst_event_irq: assert property (@(posedge pclk) disable iff (!presetn)
    sw_reset_pulse |=> irq_stat_reg[1])
    else $error("software reset status not set");

  a_stat_read_clear: assert property (@(posedge pclk) disable iff (!presetn)
    rd_en && paddr == `CSRV_OFF_IRQ_STAT |=> irq_stat_reg == $past(irq_ev))
    else $error("status read did not clear");

  a_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
    irq == $past(|(irq_stat_reg & irq_mask_reg)))
    else $error("interrupt output wrong");

  a_pready_pulse: assert property (@(posedge pclk) disable iff (!presetn)
    pready |=> !pready)
    else $error("ready held too long");

  a_err_with_ready: assert property (@(posedge pclk) disable iff (!presetn)
    pslverr |-> pready)
    else $error("error without ready");

  a_prdata_idle: assert property (@(posedge pclk) disable iff (!presetn)
    !pready |-> prdata == 32'h00000000)
    else $error("read data outside answer");

  a_unmapped_zero: assert property (@(posedge pclk) disable iff (!presetn)
    pslverr |-> prdata == 32'h00000000)
    else $error("unmapped read data not zero");
endmodule : csrv_top
